// [src/bpf_pkg.sv]
`default_nettype none
package bpf_pkg;
   localparam int GROUP_SLOTS   = 4;
   localparam int GROUP_BYTES   = 16;
   localparam int GHIST_W       = 9;
   localparam int PHT_ENTRIES   = 4096;
   localparam int PHT_IDX_W     = 12;
   localparam int BTB_ENTRIES   = 16;
   localparam int RAS_ENTRIES   = 4;
   localparam int RET_OFFSET    = 8;
   localparam int REDIRECT_PENALTY_CYC = 10;
   localparam int STORE_LAT_CYC = 4;
   localparam logic [31:0] RESET_PC  = 32'h0000_0000;
   localparam logic [1:0]  CTR_RESET = 2'h1;

   typedef enum logic [2:0] {
      KIND_NONE   = 3'b000,
      KIND_COND   = 3'b001,
      KIND_LIKELY = 3'b010,
      KIND_JUMP   = 3'b011,
      KIND_CALL   = 3'b100,
      KIND_INDIR  = 3'b101,
      KIND_RET31  = 3'b110
   } bpf_kind_e;

   typedef enum logic [1:0] {
      SIZE_BYTE  = 2'b00,
      SIZE_HALF  = 2'b01,
      SIZE_WORD  = 2'b10,
      SIZE_DWORD = 2'b11
   } bpf_size_e;

   typedef struct packed {
      logic        valid;
      logic [29:0] tag;
      logic [31:0] target;
   } bpf_btb_s;

   typedef struct packed {
      logic            valid;
      logic [31:0]     pc;
      logic [3:0]      mask;
      logic [3:0][2:0] kind;
      logic [3:0][31:0] target;
   } bpf_grp_s;

   typedef struct packed {
      logic       found;
      logic [1:0] idx;
   } bpf_br_s;
endpackage : bpf_pkg
`default_nettype wire

// [src/bpf_pht_if.sv]
`default_nettype none
interface bpf_pht_if #(parameter int AW = 12, parameter int DW = 2);
   logic [AW-1:0] rd_addr;
   logic [DW-1:0] rd_data;
   logic          wr_en;
   logic [AW-1:0] wr_addr;
   logic [DW-1:0] wr_data;
   modport core (output rd_addr, input rd_data, output wr_en, output wr_addr, output wr_data);
   modport mem  (input rd_addr, output rd_data, input wr_en, input wr_addr, input wr_data);
endinterface : bpf_pht_if
`default_nettype wire

// [src/bpf_pht_mem.sv]
`default_nettype none
module bpf_pht_mem
   import bpf_pkg::*;
#(
   parameter int DEPTH = PHT_ENTRIES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Table port
   bpf_pht_if.mem   pht
);
   typedef struct packed {
      logic [1:0] rd_data;
   } bpf_mem_s;

   logic [1:0] table_reg [DEPTH];
   bpf_mem_s   st_reg;
   bpf_mem_s   st_next;

   always_comb begin
      st_next         = st_reg;
      st_next.rd_data = table_reg[pht.rd_addr];
   end

   // Counters start weakly not-taken
   always_ff @(posedge clock) begin
      if (reset) begin
         st_reg <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            table_reg[i] <= CTR_RESET;
         end
      end else begin
         st_reg <= st_next;
         if (pht.wr_en) begin
            table_reg[pht.wr_addr] <= pht.wr_data;
         end
      end
   end

   assign pht.rd_data = st_reg.rd_data;
endmodule : bpf_pht_mem
`default_nettype wire

// [src/bpf_fetch.sv]
`default_nettype none
module bpf_fetch
   import bpf_pkg::*;
(
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             reset,
   // Instruction cache
   output logic [31:0]           fetch_pc,
   output logic                  fetch_req,
   input  wire logic             line_valid,
   input  wire logic [3:0][2:0]  line_kind,
   input  wire logic [3:0][31:0] line_target,
   // Decode side
   output logic                  dec_valid,
   output logic [31:0]           dec_pc,
   output logic [3:0]            dec_mask,
   output logic                  dec_taken,
   output logic [1:0]            dec_slot,
   output logic [31:0]           dec_target,
   output logic [8:0]            dec_ghist,
   output logic [1:0]            dec_ctr,
   // Branch resolution
   input  wire logic             res_valid,
   input  wire logic             res_cond,
   input  wire logic             res_indirect,
   input  wire logic             res_taken,
   input  wire logic             res_mispredict,
   input  wire logic [31:0]      res_pc,
   input  wire logic [31:0]      res_target,
   input  wire logic [8:0]       res_ghist,
   input  wire logic [1:0]       res_ctr,
   // Memory access check
   input  wire logic             mem_valid,
   input  wire logic             mem_store,
   input  wire logic [1:0]       mem_size,
   input  wire logic [2:0]       mem_addr_lo,
   input  wire logic [4:0]       mem_dest,
   output logic                  addr_exc,
   output logic                  prefetch,
   output logic                  store_busy,
   output logic                  store_done
);
   typedef struct packed {
      logic [31:0]           fetch_pc;
      logic                  fetch_req;
      logic [3:0]            pen;
      bpf_grp_s              s1;
      bpf_grp_s              s2;
      logic                  dec_valid;
      logic [31:0]           dec_pc;
      logic [3:0]            dec_mask;
      logic                  dec_taken;
      logic [1:0]            dec_slot;
      logic [31:0]           dec_target;
      logic [8:0]            dec_ghist;
      logic [1:0]            dec_ctr;
      logic [8:0]            global_branch_history;
      logic [3:0][31:0]      ras;
      logic [1:0]            ras_ptr;
      bpf_btb_s [15:0]       indirect_target_buffer;
      logic [3:0]            btb_rr;
      logic                  addr_exc;
      logic                  prefetch;
      logic                  store_done;
      logic                  store_busy;
      logic [2:0]            store_cnt;
   } bpf_state_s;

   bpf_state_s st_reg;
   bpf_state_s st_next;
   bpf_br_s    br;
   logic       taken;
   logic       second;
   logic       stall;
   logic       redirect;
   logic       misaligned;
   logic [31:0] tgt;
   logic [3:0]  keep;

   bpf_pht_if #(.AW(PHT_IDX_W), .DW(2)) pht ();

   bpf_pht_mem #(.DEPTH(PHT_ENTRIES)) u_pht (
      .clock (clock),
      .reset (reset),
      .pht   (pht.mem)
   );

   function automatic bpf_br_s find_br(input logic [3:0][2:0] k, input logic [3:0] m);
      bpf_br_s b;
      b = '0;
      for (int i = 3; i >= 0; i--) begin
         if (m[i] && k[i] != KIND_NONE) begin
            b.found = 1'b1;
            b.idx   = 2'(i);
         end
      end
      return b;
   endfunction : find_br

   function automatic logic [3:0] keep_upto(input logic [1:0] i);
      unique case (i)
         2'h0:    return 4'h3;
         2'h1:    return 4'h7;
         default: return 4'hF;
      endcase
   endfunction : keep_upto

   function automatic logic [11:0] pht_index(input logic [31:0] pc, input logic [8:0] gh);
      return pc[15:4] ^ {3'h0, gh};
   endfunction : pht_index

   always_comb begin
      st_next            = st_reg;
      st_next.addr_exc   = 1'b0;
      st_next.prefetch   = 1'b0;
      st_next.store_done = 1'b0;
      st_next.dec_valid  = 1'b0;
      pht.wr_en   = 1'b0;
      pht.wr_addr = '0;
      pht.wr_data = '0;
      br       = find_br(st_reg.s2.kind, st_reg.s2.mask);
      keep     = keep_upto(br.idx);
      taken    = 1'b0;
      tgt      = st_reg.s2.target[br.idx];
      second   = find_br(st_reg.s2.kind, st_reg.s2.mask & ~keep).found;
      // Predict the first branch still pending in stage 2
      if (st_reg.s2.valid && br.found) begin
         unique case (bpf_kind_e'(st_reg.s2.kind[br.idx]))
            KIND_COND: taken = pht.rd_data[1];
            KIND_LIKELY, KIND_JUMP, KIND_CALL: taken = 1'b1;
            KIND_INDIR: begin
               for (int i = 0; i < BTB_ENTRIES; i++) begin
                  if (st_reg.indirect_target_buffer[i].valid
                      && st_reg.indirect_target_buffer[i].tag == {st_reg.s2.pc[31:4], br.idx}) begin
                     taken = 1'b1;
                     tgt   = st_reg.indirect_target_buffer[i].target;
                  end
               end
            end
            KIND_RET31: begin
               taken = 1'b1;
               tgt   = st_reg.ras[st_reg.ras_ptr - 2'h1];
            end
            default: taken = 1'b0;
         endcase
      end
      redirect = st_reg.s2.valid && br.found && taken;
      stall    = st_reg.s2.valid && br.found && !taken && second;
      if (st_reg.s2.valid && st_reg.s2.mask != 4'h0) begin
         st_next.dec_valid  = 1'b1;
         st_next.dec_pc     = st_reg.s2.pc;
         st_next.dec_mask   = (redirect || stall) ? (st_reg.s2.mask & keep)
                                                  : st_reg.s2.mask;
         st_next.dec_taken  = redirect;
         st_next.dec_slot   = br.idx;
         st_next.dec_target = tgt;
         st_next.dec_ghist  = st_reg.global_branch_history;
         st_next.dec_ctr    = pht.rd_data;
      end
      if (redirect && st_reg.s2.kind[br.idx] == KIND_CALL) begin
         st_next.ras[st_reg.ras_ptr] = {st_reg.s2.pc[31:4], br.idx, 2'h0} + 32'(RET_OFFSET);
         st_next.ras_ptr             = st_reg.ras_ptr + 2'h1;
      end else if (redirect && st_reg.s2.kind[br.idx] == KIND_RET31) begin
         st_next.ras_ptr = st_reg.ras_ptr - 2'h1;
      end
      // Stage movement
      if (stall) begin
         st_next.s2.mask = st_reg.s2.mask & ~keep;
      end else begin
         st_next.s2 = st_reg.s1;
         if (redirect) begin
            st_next.s2.mask  = (br.idx == 2'h3 && st_reg.s1.valid) ? (st_reg.s1.mask & 4'h1)
                                                                   : 4'h0;
            st_next.s2.valid = st_next.s2.mask != 4'h0;
            st_next.s1.valid = 1'b0;
            st_next.fetch_pc = tgt;
         end else if (st_reg.fetch_req && line_valid) begin
            st_next.s1.valid  = 1'b1;
            st_next.s1.pc     = st_reg.fetch_pc;
            st_next.s1.mask   = 4'hF << st_reg.fetch_pc[3:2];
            st_next.s1.kind   = line_kind;
            st_next.s1.target = line_target;
            st_next.fetch_pc  = {st_reg.fetch_pc[31:4] + 28'h1, 4'h0};
         end else begin
            st_next.s1.valid = 1'b0;
         end
      end
      // Resolution updates
      if (res_valid && res_cond) begin
         st_next.global_branch_history = {res_ghist[7:0], res_taken};
         pht.wr_en   = 1'b1;
         pht.wr_addr = pht_index(res_pc, res_ghist);
         pht.wr_data = res_taken ? ((res_ctr == 2'h3) ? 2'h3 : res_ctr + 2'h1)
                                 : ((res_ctr == 2'h0) ? 2'h0 : res_ctr - 2'h1);
      end
      if (res_valid && res_indirect) begin
         st_next.indirect_target_buffer[st_reg.btb_rr] = '{1'b1, res_pc[31:2], res_target};
         for (int i = 0; i < BTB_ENTRIES; i++) begin
            if (st_reg.indirect_target_buffer[i].valid && st_reg.indirect_target_buffer[i].tag == res_pc[31:2]) begin
               st_next.indirect_target_buffer[st_reg.btb_rr] = st_reg.indirect_target_buffer[st_reg.btb_rr];
               st_next.indirect_target_buffer[i].target      = res_target;
            end
         end
         st_next.btb_rr = st_reg.btb_rr + 4'h1;
      end
      if (st_reg.pen != 4'h0) begin
         st_next.pen = st_reg.pen - 4'h1;
      end
      if (res_valid && res_mispredict) begin
         st_next.s1.valid  = 1'b0;
         st_next.s2.valid  = 1'b0;
         st_next.dec_valid = 1'b0;
         st_next.fetch_pc  = res_target;
         st_next.pen       = 4'(REDIRECT_PENALTY_CYC);
      end
      st_next.fetch_req = st_next.pen == 4'h0;
      pht.rd_addr = pht_index(st_next.s2.pc, st_reg.global_branch_history);
      // Memory access checks
      misaligned = (mem_addr_lo & ((3'h1 << mem_size) - 3'h1)) != 3'h0;
      if (mem_valid) begin
         st_next.addr_exc = misaligned;
         st_next.prefetch = !mem_store && !misaligned && mem_dest == 5'h00;
         if (mem_store && !misaligned && st_reg.store_cnt == 3'h0) begin
            st_next.store_cnt = 3'(STORE_LAT_CYC);
         end
      end
      if (st_reg.store_cnt != 3'h0) begin
         st_next.store_cnt  = st_reg.store_cnt - 3'h1;
         st_next.store_done = st_reg.store_cnt == 3'h2;
      end
      st_next.store_busy = st_next.store_cnt != 3'h0;
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         st_reg           <= '0;
         st_reg.fetch_pc  <= RESET_PC;
         st_reg.fetch_req <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign fetch_pc   = st_reg.fetch_pc;
   assign fetch_req  = st_reg.fetch_req;
   assign dec_valid  = st_reg.dec_valid;
   assign dec_pc     = st_reg.dec_pc;
   assign dec_mask   = st_reg.dec_mask;
   assign dec_taken  = st_reg.dec_taken;
   assign dec_slot   = st_reg.dec_slot;
   assign dec_target = st_reg.dec_target;
   assign dec_ghist  = st_reg.dec_ghist;
   assign dec_ctr    = st_reg.dec_ctr;
   assign addr_exc   = st_reg.addr_exc;
   assign prefetch   = st_reg.prefetch;
   assign store_busy = st_reg.store_busy;
   assign store_done = st_reg.store_done;

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   property p_group_in_line;
      dec_valid |-> (dec_mask & ~(4'hF << dec_pc[3:2])) == 4'h0;
   endproperty
   a_group_in_line: assert property (p_group_in_line) else $error("group left its line");

   property p_drop_trailing;
      dec_valid && dec_taken |-> (dec_mask & ~keep_upto(dec_slot)) == 4'h0;
   endproperty
   a_drop_trailing: assert property (p_drop_trailing) else $error("slots kept after delay");

   property p_second_branch_stall;
      stall && !(res_valid && res_mispredict) |=> $stable(fetch_pc);
   endproperty
   a_second_branch_stall: assert property (p_second_branch_stall) else $error("no stall");

   sequence s_seq_fetch;
      fetch_req && line_valid && !redirect && !stall && !(res_valid && res_mispredict);
   endsequence
   property p_seq_step;
      s_seq_fetch |=> fetch_pc == {$past(fetch_pc[31:4]) + 28'h1, 4'h0};
   endproperty
   a_seq_step: assert property (p_seq_step) else $error("sequential fetch not +16");

   property p_redirect_target;
      redirect && !(res_valid && res_mispredict) |=> fetch_pc == $past(tgt) && dec_valid
                                                     && dec_taken;
   endproperty
   a_redirect_target: assert property (p_redirect_target) else $error("bad redirect");

   property p_mispredict_penalty;
      res_valid && res_mispredict |=> (fetch_pc == $past(res_target) && !fetch_req)
                                      ##1 !fetch_req [*8] ##1 !fetch_req ##1 fetch_req;
   endproperty
   a_mispredict_penalty: assert property (p_mispredict_penalty) else $error("penalty short");

   property p_misaligned;
      mem_valid && misaligned |=> addr_exc && !prefetch;
   endproperty
   a_misaligned: assert property (p_misaligned) else $error("no address exception");

   property p_prefetch;
      mem_valid && !mem_store && !misaligned && mem_dest == 5'h00 |=> prefetch;
   endproperty
   a_prefetch: assert property (p_prefetch) else $error("no prefetch");

   sequence s_store_start;
      mem_valid && mem_store && !misaligned && !store_busy;
   endsequence
   property p_store_latency;
      s_store_start |=> (store_busy && !store_done) [*3] ##1 store_done;
   endproperty
   a_store_latency: assert property (p_store_latency) else $error("store latency wrong");

   property p_history;
      res_valid && res_cond |=> st_reg.global_branch_history == {$past(res_ghist[7:0]), $past(res_taken)};
   endproperty
   a_history: assert property (p_history) else $error("history not repaired");
endmodule : bpf_fetch
`default_nettype wire

// [tb/bpf_icache_model.sv]
`default_nettype none
module bpf_icache_model
   import bpf_pkg::*;
(
   // Clock
   input  wire logic             clock,
   // Fetch request
   input  wire logic [31:0]      fetch_pc,
   input  wire logic             fetch_req,
   input  wire logic             slow,
   // Group answer
   output logic                  line_valid,
   output logic [3:0][2:0]       line_kind,
   output logic [3:0][31:0]      line_target
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [3:0][2:0]  kind_mem [16];
   logic [3:0][31:0] tgt_mem  [16];
   logic [7:0]       beat_reg = 8'h00;

   // Free-running beat for slow answers and idle patterns
   always_ff @(posedge clock) begin
      beat_reg <= beat_reg + 8'h01;
   end

   // One whole line per answer; idle lines show a moving pattern
   always_comb begin
      line_valid  = fetch_req && !(slow && beat_reg[0]);
      line_kind   = line_valid ? kind_mem[fetch_pc[7:4]] : {4{beat_reg[2:0]}};
      line_target = line_valid ? tgt_mem[fetch_pc[7:4]] : {4{{24'h5A5A5A, beat_reg}}};
   end
endmodule : bpf_icache_model
`default_nettype wire

// [tb/test_branch_predict_fetch.sv]
`default_nettype none
module test_branch_predict_fetch
   import bpf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic             clock, reset, slow, fetch_req, line_valid;
   logic [31:0]      fetch_pc, dec_pc, dec_target, res_pc, res_target;
   logic [3:0][2:0]  line_kind;
   logic [3:0][31:0] line_target;
   logic             dec_valid, dec_taken, res_valid, res_cond, res_indirect;
   logic             res_taken, res_mispredict, mem_valid, mem_store;
   logic             addr_exc, prefetch, store_busy, store_done;
   logic [3:0]       dec_mask;
   logic [1:0]       dec_slot, dec_ctr, res_ctr, mem_size;
   logic [8:0]       dec_ghist, res_ghist;
   logic [2:0]       mem_addr_lo;
   logic [4:0]       mem_dest;
   int               failures, n_tests;

   bpf_fetch bpf_fetch_i (.clock, .reset, .fetch_pc, .fetch_req, .line_valid, .line_kind,
      .line_target, .dec_valid, .dec_pc, .dec_mask, .dec_taken, .dec_slot, .dec_target,
      .dec_ghist, .dec_ctr, .res_valid, .res_cond, .res_indirect, .res_taken,
      .res_mispredict, .res_pc, .res_target, .res_ghist, .res_ctr, .mem_valid, .mem_store,
      .mem_size, .mem_addr_lo, .mem_dest, .addr_exc, .prefetch, .store_busy, .store_done);

   bpf_icache_model bpf_icache_model_i (.clock, .fetch_pc, .fetch_req, .slow, .line_valid,
      .line_kind, .line_target);

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   task automatic step;
      @(posedge clock);
      #1;
   endtask : step

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out

   task automatic wait_dec;
      int n;
      n = 0;
      step();
      while (dec_valid !== 1'b1 && n < 60) begin
         step();
         n++;
      end
      if (n == 60) begin
         failures++;
         close_out();
      end
   endtask : wait_dec

   task automatic clr;
      for (int i = 0; i < 16; i++) begin
         bpf_icache_model_i.kind_mem[i] = '0;
         bpf_icache_model_i.tgt_mem[i]  = '0;
      end
   endtask : clr

   task automatic prog(input int g, input int s, input logic [2:0] k, input logic [31:0] t);
      bpf_icache_model_i.kind_mem[g][s] = k;
      bpf_icache_model_i.tgt_mem[g][s]  = t;
   endtask : prog

   task automatic res(input logic [31:0] pc, input logic [31:0] tgt, input logic cond,
                      input logic ind, input logic tk, input logic misp, input logic [8:0] gh);
      step();
      {res_pc, res_target, res_cond, res_indirect} = {pc, tgt, cond, ind};
      {res_taken, res_mispredict, res_ghist} = {tk, misp, gh};
      res_valid = 1'b1;
      step();
      res_valid = 1'b0;
   endtask : res

   task automatic go(input logic [31:0] tgt, input logic cond, input logic [8:0] gh);
      int n;
      n = 0;
      res(32'h0, tgt, cond, 1'b0, 1'b1, 1'b1, gh);
      chk(fetch_pc, tgt);
      chk(fetch_req, 32'h0);
      while (fetch_req !== 1'b1 && n < 30) begin
         step();
         n++;
      end
      chk(n, 32'hA);
      if (n == 30) begin
         close_out();
      end
   endtask : go

   task automatic t_seq;
      clr();
      slow = 1'b1;
      go(32'h48, 1'b0, 9'h0);
      wait_dec();
      chk(dec_pc, 32'h48);
      chk(dec_mask, 32'hC);
      wait_dec();
      chk(dec_pc, 32'h50);
      chk(dec_mask, 32'hF);
      slow = 1'b0;
   endtask : t_seq

   task automatic t_taken(input logic [2:0] k, input int s);
      clr();
      prog(8, s, k, 32'hC0);
      go(32'h80, 1'b0, 9'h0);
      step();
      chk(fetch_pc, 32'h90);
      step();
      chk(fetch_pc, 32'hA0);
      step();
      chk(fetch_pc, 32'hC0);
      chk(dec_valid, 32'h1);
      chk(dec_taken, 32'h1);
      chk(dec_slot, s);
      chk(dec_target, 32'hC0);
      chk(dec_mask, s == 3 ? 32'hF : (32'h1 << (s + 2)) - 32'h1);
      if (s == 3) begin
         wait_dec();
         chk(dec_pc, 32'h90);
         chk(dec_mask, 32'h1);
      end
      wait_dec();
      chk(dec_pc, 32'hC0);
   endtask : t_taken

   task automatic t_two;
      clr();
      prog(2, 0, KIND_COND, 32'h0);
      prog(2, 2, KIND_COND, 32'h0);
      go(32'h20, 1'b1, 9'h0A5);
      wait_dec();
      chk(dec_mask, 32'h3);
      chk(dec_ghist, 32'h14B);
      chk(dec_ctr, CTR_RESET);
      chk(dec_taken, 32'h0);
      wait_dec();
      chk(dec_mask, 32'hC);
      wait_dec();
      chk(dec_pc, 32'h30);
   endtask : t_two

   task automatic t_cond;
      clr();
      prog(2, 1, KIND_COND, 32'h70);
      res_ctr = 2'h2;
      go(32'h20, 1'b1, 9'h001);
      res_ctr = 2'h0;
      wait_dec();
      chk(dec_taken, 32'h1);
      chk(dec_ctr, 32'h3);
      chk(dec_ghist, 32'h3);
      chk(dec_slot, 32'h1);
      chk(dec_target, 32'h70);
      chk(dec_mask, 32'h7);
      wait_dec();
      chk(dec_pc, 32'h70);
   endtask : t_cond

   task automatic t_ind;
      clr();
      prog(6, 1, KIND_INDIR, 32'h0);
      res(32'h64, 32'hA0, 1'b0, 1'b1, 1'b1, 1'b0, 9'h0);
      go(32'h60, 1'b0, 9'h0);
      wait_dec();
      chk(dec_taken, 32'h1);
      chk(dec_target, 32'hA0);
      for (int i = 0; i < BTB_ENTRIES; i++) begin
         res(32'h1000 + 4 * i, 32'h0, 1'b0, 1'b1, 1'b1, 1'b0, 9'h0);
      end
      go(32'h60, 1'b0, 9'h0);
      wait_dec();
      chk(dec_taken, 32'h0);
   endtask : t_ind

   task automatic t_ret;
      clr();
      prog(12, 0, KIND_CALL, 32'hE0);
      prog(14, 0, KIND_RET31, 32'h0);
      go(32'hC0, 1'b0, 9'h0);
      wait_dec();
      chk(dec_target, 32'hE0);
      wait_dec();
      chk(dec_pc, 32'hE0);
      chk(dec_taken, 32'h1);
      chk(dec_target, 32'hC8);
   endtask : t_ret

   task automatic mem_op(input logic st, input logic [1:0] sz, input logic [2:0] lo,
                         input logic [4:0] d);
      step();
      {mem_store, mem_size, mem_addr_lo, mem_dest} = {st, sz, lo, d};
      mem_valid = 1'b1;
      step();
      mem_valid = 1'b0;
   endtask : mem_op

   task automatic t_mem;
      logic [1:0] sz [6];
      logic [2:0] lo [6];
      sz = '{2'h1, 2'h2, 2'h3, 2'h2, 2'h0, 2'h3};
      lo = '{3'h1, 3'h2, 3'h4, 3'h4, 3'h3, 3'h0};
      for (int i = 0; i < 6; i++) begin
         mem_op(1'b0, sz[i], lo[i], 5'h3);
         chk(addr_exc, i < 3);
         chk(prefetch, 32'h0);
      end
      mem_op(1'b0, 2'h2, 3'h4, 5'h0);
      chk(prefetch, 32'h1);
      mem_op(1'b1, 2'h3, 3'h0, 5'h0);
      for (int i = 1; i <= 5; i++) begin
         chk(store_busy, i < 5);
         chk(store_done, i == 4);
         mem_valid = (i == 2);
         step();
      end
   endtask : t_mem

   initial begin
      {reset, slow, res_valid, res_cond, res_indirect, res_taken} = 6'h20;
      {res_mispredict, mem_valid, mem_store, mem_size, mem_addr_lo, mem_dest} = '0;
      {res_pc, res_target, res_ghist, res_ctr} = '0;
      failures = 0;
      n_tests = 0;
      clr();
      repeat (16) @(posedge clock);
      #1;
      chk(fetch_pc, RESET_PC);
      chk(fetch_req, 32'h1);
      chk(dec_valid, 32'h0);
      chk(store_busy, 32'h0);
      reset = 1'b0;
      t_seq();
      t_taken(KIND_JUMP, 1);
      t_taken(KIND_LIKELY, 0);
      t_taken(KIND_CALL, 2);
      t_taken(KIND_JUMP, 3);
      t_two();
      t_cond();
      t_ind();
      t_ret();
      t_mem();
      close_out();
   end
endmodule : test_branch_predict_fetch
`default_nettype wire
